// ### logic/eimp_defs.vh
// Register offsets, field layouts, reset values and timing counts
`ifndef EIMP_DEFS_VH
`define EIMP_DEFS_VH
// Byte offsets of the register words
`define EIMP_OFF_INT_CONTROL 8'h00
`define EIMP_OFF_RX_THR_EN 8'h04
`define EIMP_OFF_RX_EN 8'h08
`define EIMP_OFF_TX_EN 8'h0C
`define EIMP_OFF_MISC_EN 8'h10
`define EIMP_OFF_RX_THR_STAT 8'h14
`define EIMP_OFF_RX_STAT 8'h18
`define EIMP_OFF_TX_STAT 8'h1C
`define EIMP_OFF_MISC_STAT 8'h20
`define EIMP_OFF_RX_LIMIT 8'h24
`define EIMP_OFF_TX_LIMIT 8'h28
`define EIMP_OFF_EVT_STAT 8'h2C
`define EIMP_OFF_EVT_EN 8'h30
`define EIMP_OFF_EVT_CLR 8'h34
// Field positions in the interrupt control word
`define EIMP_PACE_RX_BIT 16
`define EIMP_PACE_TX_BIT 17
`define EIMP_PRESCALE_W 12
// Reset values
`define EIMP_RST_ZERO 32'h0000_0000
`define EIMP_RST_LIMIT 6'h00
// Pacing time base: prescaler ticks of 4 us per 1 ms window
`define EIMP_TICK_US 4
`define EIMP_WINDOW_US 1000
`define EIMP_TICKS_PER_MS (`EIMP_WINDOW_US / `EIMP_TICK_US)
// Last tick count of the 250-tick window
`define EIMP_TICK_LAST 8'hF9
// Prescaler counts clk/6 periods, so one prescaler step is six clocks per unit of the prescaler value
`define EIMP_CLK_DIV 15'h0006
// Unmapped reads return this word
`define EIMP_UNMAPPED 32'h0000_0000
`endif

// ### logic/eimp_pacer.v
// Pacing limiter for one interrupt pulse output
`timescale 1ns/1ps
`include "eimp_defs.vh"
module eimp_pacer (
	input wire mclk,
	input wire arst_n,
	input wire enable,
	input wire [5:0] limit,
	input wire ms_tick,
	input wire req,
	output reg pulse_q
);
	reg [5:0] count_q;
	reg was_q;
	// ************************************************************
	// Count pulses issued in the current millisecond window
	// ************************************************************
	// A rising edge of the request counts as one issued interrupt.
	// When the budget is spent the output waits for the next window.
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			count_q <= 6'h00;
			was_q <= 1'b0;
			pulse_q <= 1'b0;
		end else begin
			if (!enable) begin
				pulse_q <= req; // Bypass
				count_q <= 6'h00;
				was_q <= req;
			end else begin
				if (req && !was_q && count_q < limit) begin
					pulse_q <= 1'b1;
					was_q <= 1'b1;
					count_q <= ms_tick ? 6'h01 : count_q + 6'h01;
				end else begin
					if (!req) begin
						pulse_q <= 1'b0;
						was_q <= 1'b0;
					end
					if (ms_tick) begin
						count_q <= 6'h00;
					end
				end
			end
		end
	end
endmodule

// ### logic/eimp_top.v
// Interrupt mask, masked status and pacing for an Ethernet MAC subsystem
// Function
// - four-bit misc mask: stats, host error, link change, user access.
// - misc source raises misc pulse only when its mask bit set; resets zero.
// - eight-bit threshold status shows enabled and asserting sources.
// - eight-bit receive status shows enabled asserting channels; resets zero.
// - eight-bit transmit status shows enabled asserting channels.
// - four-bit misc status shows enabled asserting sources; resets zero.
// - six-bit receive limit caps receive pulses per millisecond when paced.
// - reserved bits read zero and ignore writes.
// - pacing enable bits select pacing or bypass per pulse.
// - eight-bit receive mask selects sources for receive pulse.
`timescale 1ns/1ps
`include "eimp_defs.vh"
module eimp_top (
	input wire mclk,
	input wire arst_n,
	input wire [7:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	output reg [31:0] avs_readdata,
	output reg avs_waitrequest,
	input wire [7:0] rx_threshold_src,
	input wire [7:0] rx_src,
	input wire [7:0] tx_src,
	input wire statistics_pending,
	input wire host_error_pending,
	input wire management_link_change_event,
	input wire management_user_access_event,
	output wire receive_threshold_interrupt_pulse,
	output wire rx_pulse,
	output wire tx_pulse,
	output reg misc_pulse_q,
	output reg irq_q
);
	// ************************************************************
	// Registers
	// ************************************************************
	// Software-written configuration
	reg [1:0] pacing_enable_bits_q;
	reg [11:0] pacing_prescaler_q;
	reg [7:0] rx_thr_en_q;
	reg [7:0] rx_en_q;
	reg [7:0] tx_en_q;
	reg [3:0] misc_en_q;
	reg [5:0] rx_pacing_limit_q;
	reg [5:0] tx_pacing_limit_q;
	reg [3:0] evt_en_q;
	// Sticky event flags and their edge history
	reg [3:0] evt_stat_q;
	reg [3:0] evt_prev_q;
	// Masked status, one clock behind the raw sources
	reg [7:0] rx_thr_stat_q;
	reg [7:0] rx_stat_q;
	reg [7:0] tx_stat_q;
	reg [3:0] misc_stat_q;
	reg thr_pulse_q;
	// Bus handshake state
	reg done_q;
	// Pacing time base
	reg [14:0] pre_cnt_q;
	reg [7:0] tick_cnt_q;
	reg ms_tick_q;
	// Combinational helpers
	wire [3:0] misc_src;
	wire [7:0] thr_masked;
	wire [7:0] rx_masked;
	wire [7:0] tx_masked;
	wire [3:0] misc_masked;
	wire bus_req;
	wire first_cyc;
	wire [14:0] pre_wide;
	wire [14:0] pre_last;
	wire rx_req;
	wire tx_req;
	wire [3:0] evt_now;
	wire [3:0] evt_rise;
	wire clr_hit;
	wire wr_hit;
	wire [31:0] ctrl_word;
	wire [31:0] rd_word;

	// Decode of a register offset against the bus address
	function hit;
		input [7:0] addr;
		input [7:0] off;
		begin
			hit = (addr == off);
		end
	endfunction

	// Bit 3 statistics, bit 2 host error, bit 1 link, bit 0 user access
	assign misc_src = {statistics_pending, host_error_pending,
		management_link_change_event, management_user_access_event};

	// Each source passes only while its enable bit is set
	assign thr_masked = rx_threshold_src & rx_thr_en_q;
	assign rx_masked = rx_src & rx_en_q;
	assign tx_masked = tx_src & tx_en_q;
	assign misc_masked = misc_src & misc_en_q;

	// ************************************************************
	// Avalon slave: one wait cycle, then the answer
	// ************************************************************
	// Waitrequest is high on the first request cycle and low on the
	// second, so every access completes two edges after it starts.
	assign bus_req = avs_read || avs_write;
	assign first_cyc = bus_req && !done_q;
	// A write lands only on the edge at which the master sees the answer
	assign wr_hit = avs_write && !avs_waitrequest;
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			avs_waitrequest <= 1'b1;
			done_q <= 1'b0;
			avs_readdata <= `EIMP_RST_ZERO;
		end else begin
			done_q <= first_cyc;
			// Back to back requests still see one wait cycle each
			avs_waitrequest <= !first_cyc;
			if (avs_read && first_cyc) begin
				avs_readdata <= rd_word;
			end
		end
	end

	// Control word; pacing bits 21:18 are not stored and read zero
	assign ctrl_word = {10'h0, 4'h0, pacing_enable_bits_q, 4'h0,
		pacing_prescaler_q};

	// Read multiplexer; unused bits stay zero
	assign rd_word =
		hit(avs_address, `EIMP_OFF_INT_CONTROL) ? ctrl_word :
		hit(avs_address, `EIMP_OFF_RX_THR_EN) ? {24'h000000, rx_thr_en_q} :
		hit(avs_address, `EIMP_OFF_RX_EN) ? {24'h000000, rx_en_q} :
		hit(avs_address, `EIMP_OFF_TX_EN) ? {24'h000000, tx_en_q} :
		hit(avs_address, `EIMP_OFF_MISC_EN) ? {28'h0000000, misc_en_q} :
		hit(avs_address, `EIMP_OFF_RX_THR_STAT) ?
			{24'h000000, rx_thr_stat_q} :
		hit(avs_address, `EIMP_OFF_RX_STAT) ? {24'h000000, rx_stat_q} :
		hit(avs_address, `EIMP_OFF_TX_STAT) ? {24'h000000, tx_stat_q} :
		hit(avs_address, `EIMP_OFF_MISC_STAT) ?
			{28'h0000000, misc_stat_q} :
		hit(avs_address, `EIMP_OFF_RX_LIMIT) ?
			{26'h0, rx_pacing_limit_q} :
		hit(avs_address, `EIMP_OFF_TX_LIMIT) ?
			{26'h0, tx_pacing_limit_q} :
		hit(avs_address, `EIMP_OFF_EVT_STAT) ? {28'h0000000, evt_stat_q} :
		hit(avs_address, `EIMP_OFF_EVT_EN) ? {28'h0000000, evt_en_q} :
		`EIMP_UNMAPPED;

	// ************************************************************
	// Writable configuration
	// ************************************************************
	// Only the defined field bits are stored, so reserved writes vanish.
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			pacing_enable_bits_q <= 2'h0;
			pacing_prescaler_q <= 12'h000;
			rx_thr_en_q <= 8'h00;
			rx_en_q <= 8'h00;
			tx_en_q <= 8'h00;
			misc_en_q <= 4'h0;
			rx_pacing_limit_q <= `EIMP_RST_LIMIT;
			tx_pacing_limit_q <= `EIMP_RST_LIMIT;
			evt_en_q <= 4'h0;
		end else if (wr_hit) begin
			if (hit(avs_address, `EIMP_OFF_INT_CONTROL)) begin
				pacing_enable_bits_q <= avs_writedata[17:16];
				pacing_prescaler_q <= avs_writedata[11:0];
			end
			if (hit(avs_address, `EIMP_OFF_RX_THR_EN)) begin
				rx_thr_en_q <= avs_writedata[7:0];
			end
			if (hit(avs_address, `EIMP_OFF_RX_EN)) begin
				rx_en_q <= avs_writedata[7:0];
			end
			if (hit(avs_address, `EIMP_OFF_TX_EN)) begin
				tx_en_q <= avs_writedata[7:0];
			end
			if (hit(avs_address, `EIMP_OFF_MISC_EN)) begin
				misc_en_q <= avs_writedata[3:0];
			end
			if (hit(avs_address, `EIMP_OFF_RX_LIMIT)) begin
				rx_pacing_limit_q <= avs_writedata[5:0];
			end
			if (hit(avs_address, `EIMP_OFF_TX_LIMIT)) begin
				tx_pacing_limit_q <= avs_writedata[5:0];
			end
			if (hit(avs_address, `EIMP_OFF_EVT_EN)) begin
				evt_en_q <= avs_writedata[3:0];
			end
		end
	end

	// ************************************************************
	// Masked status and level pulses
	// ************************************************************
	// Status follows source AND mask one clock later; no latching.
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rx_thr_stat_q <= 8'h00;
			rx_stat_q <= 8'h00;
			tx_stat_q <= 8'h00;
			misc_stat_q <= 4'h0;
			thr_pulse_q <= 1'b0;
			misc_pulse_q <= 1'b0;
		end else begin
			rx_thr_stat_q <= thr_masked;
			rx_stat_q <= rx_masked;
			tx_stat_q <= tx_masked;
			misc_stat_q <= misc_masked;
			thr_pulse_q <= |thr_masked;
			misc_pulse_q <= |misc_masked;
		end
	end
	assign receive_threshold_interrupt_pulse = thr_pulse_q;

	// ************************************************************
	// Pacing time base
	// ************************************************************
	// Last count of one prescaler step; fifteen bits hold the product
	// of the largest prescaler value without wrapping
	assign pre_wide = {3'h0, pacing_prescaler_q};
	assign pre_last = pre_wide * `EIMP_CLK_DIV - 15'h0001;

	// Prescaler counts clk/6 periods up to the 4 us value; 250 such
	// ticks make one millisecond window. Zero prescaler stops the base.
	// A new prescaler value acts on the step in progress, so the window
	// running at that moment may come out short or long once.
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			pre_cnt_q <= 15'h0000;
			tick_cnt_q <= 8'h00;
			ms_tick_q <= 1'b0;
		end else begin
			ms_tick_q <= 1'b0;
			if (pacing_prescaler_q == 12'h000) begin
				pre_cnt_q <= 15'h0000;
			end else if (pre_cnt_q >= pre_last) begin
				pre_cnt_q <= 15'h0000;
				if (tick_cnt_q == `EIMP_TICK_LAST) begin
					tick_cnt_q <= 8'h00;
					ms_tick_q <= 1'b1;
				end else begin
					tick_cnt_q <= tick_cnt_q + 8'h01;
				end
			end else begin
				pre_cnt_q <= pre_cnt_q + 15'h0001;
			end
		end
	end

	// Pacers see the registered status, so pulses lag one more clock
	assign rx_req = |rx_stat_q;
	assign tx_req = |tx_stat_q;

	// Receive and transmit pulses pass through pacers
	eimp_pacer u_rx_pace (
		.mclk(mclk),
		.arst_n(arst_n),
		.enable(pacing_enable_bits_q[0]),
		.limit(rx_pacing_limit_q),
		.ms_tick(ms_tick_q),
		.req(rx_req),
		.pulse_q(rx_pulse)
	);
	eimp_pacer u_tx_pace (
		.mclk(mclk),
		.arst_n(arst_n),
		.enable(pacing_enable_bits_q[1]),
		.limit(tx_pacing_limit_q),
		.ms_tick(ms_tick_q),
		.req(tx_req),
		.pulse_q(tx_pulse)
	);

	// ************************************************************
	// Sticky events and summary interrupt
	// ************************************************************
	// Events are rising edges of the four pulses; set beats clear.
	assign evt_now = {misc_pulse_q, tx_pulse, rx_pulse, thr_pulse_q};
	assign evt_rise = evt_now & ~evt_prev_q;
	assign clr_hit = wr_hit && hit(avs_address, `EIMP_OFF_EVT_CLR);
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			evt_prev_q <= 4'h0;
			evt_stat_q <= 4'h0;
			irq_q <= 1'b0;
		end else begin
			evt_prev_q <= evt_now;
			// A rise in the clearing cycle is kept, so no event is lost
			if (clr_hit) begin
				evt_stat_q <= (evt_stat_q & ~avs_writedata[3:0]) |
					evt_rise;
			end else begin
				evt_stat_q <= evt_stat_q | evt_rise;
			end
			// Level output, one clock behind the sticky flags
			irq_q <= |(evt_stat_q & evt_en_q);
		end
	end
endmodule

// ### testbench/eimp_monitor.sv
// Checker for the bus handshake and pulse outputs of the interrupt block
`timescale 1ns/1ps
module eimp_monitor (
	input wire mclk,
	input wire arst_n,
	input wire [7:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	input wire [31:0] avs_readdata,
	input wire avs_waitrequest,
	input wire [7:0] rx_threshold_src,
	input wire [7:0] rx_src,
	input wire [7:0] tx_src,
	input wire statistics_pending,
	input wire host_error_pending,
	input wire management_link_change_event,
	input wire management_user_access_event,
	input wire receive_threshold_interrupt_pulse,
	input wire rx_pulse,
	input wire tx_pulse,
	input wire misc_pulse_q,
	input wire irq_q
);
	// Misc sources in field order, bit 3 first
	wire [3:0] misc_src = {statistics_pending, host_error_pending,
		management_link_change_event, management_user_access_event};
	default clocking @(posedge mclk); endclocking
	default disable iff (!arst_n);
	// One wait cycle per access; a stuck waitrequest hangs the processor
	wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest
		|=> !avs_waitrequest) else $error("no answer after one wait");
	wait_short_a: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low too long");
	misc_cause_a: assert property ($rose(misc_pulse_q) |->
		$past(misc_src) != 4'h0) else $error("misc pulse without source");
	thr_cause_a: assert property ($rose(receive_threshold_interrupt_pulse)
		|-> $past(rx_threshold_src) != 8'h00)
		else $error("threshold pulse without source");
	rx_cause_a: assert property ($rose(rx_pulse) |->
		$past(rx_src, 2) != 8'h00) else $error("rx pulse without source");
	tx_cause_a: assert property ($rose(tx_pulse) |->
		$past(tx_src, 2) != 8'h00) else $error("tx pulse without source");
	misc_quiet_a: assert property (misc_src == 4'h0 |=>
		!misc_pulse_q) else $error("misc pulse stuck");
	rx_quiet_a: assert property (rx_src == 8'h00 |-> ##2
		!rx_pulse) else $error("rx pulse stuck");
	rdata_hold_a: assert property (!avs_read |=> $stable(avs_readdata))
		else $error("read data moved without a read");
	resv_zero_a: assert property (avs_readdata[31:18] == 14'h0000)
		else $error("upper read bits not zero");
endmodule

bind eimp_top eimp_monitor mon (.*);

// ### testbench/eimp_src_model.sv
// Far-side model: raw interrupt sources and the processor's pulse inputs
`timescale 1ns/1ps
module eimp_src_model (
	input wire mclk,
	input wire [27:0] want,
	input wire rx_pulse,
	input wire tx_pulse,
	output logic [7:0] thr,
	output logic [7:0] rx,
	output logic [7:0] tx,
	output logic [3:0] misc,
	output int rx_rises,
	output int tx_rises
);
	logic rx_prev_q = 1'b0;
	logic tx_prev_q = 1'b0;
	initial {thr, rx, tx, misc} = 28'h0000000;
	// Flags move just after an edge; the processor counts pulse rises
	always @(posedge mclk) begin
		{thr, rx, tx, misc} <= want;
		rx_prev_q <= rx_pulse;
		tx_prev_q <= tx_pulse;
		if (rx_pulse && !rx_prev_q)
			rx_rises <= rx_rises + 1;
		if (tx_pulse && !tx_prev_q)
			tx_rises <= tx_rises + 1;
	end
endmodule

// ### testbench/tb.sv
// Self-checking testbench for the interrupt mask, status and pacing block
`timescale 1ns/1ps
`include "eimp_defs.vh"
module tb;
	logic mclk = 1'b0;
	logic arst_n = 1'b0;
	logic [7:0] avs_address = 8'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	wire [31:0] avs_readdata;
	wire avs_waitrequest, receive_threshold_interrupt_pulse, rx_pulse;
	wire tx_pulse, misc_pulse_q, irq_q, statistics_pending;
	wire host_error_pending, management_link_change_event;
	wire management_user_access_event;
	wire [7:0] rx_threshold_src, rx_src, tx_src;
	logic [27:0] want = 28'h0;
	logic [31:0] rd;
	int rx_rises, tx_rises, b_rx, b_tx, err_count, checked;
	always #10 mclk = ~mclk;
	eimp_src_model model (.mclk(mclk), .want(want), .rx_pulse(rx_pulse),
		.tx_pulse(tx_pulse), .thr(rx_threshold_src), .rx(rx_src),
		.tx(tx_src), .misc({statistics_pending, host_error_pending,
		management_link_change_event, management_user_access_event}),
		.rx_rises(rx_rises), .tx_rises(tx_rises));
	eimp_top dut (.*);
	// ************************************
	// Bus and compare helpers
	// ************************************
	task check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	// Request held until waitrequest is seen low at an edge
	task acc(input logic we, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= we;
		avs_read <= !we;
		// No cycle count is assumed; only the watchdog ends a stuck wait
		do @(posedge mclk); while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	task rchk(input logic [7:0] a, input logic [31:0] exp);
		acc(1'b0, a, 32'h0);
		check(rd, exp);
	endtask
	task t_regs;
		rchk(`EIMP_OFF_MISC_EN, 32'h0);
		rchk(`EIMP_OFF_RX_STAT, 32'h0);
		rchk(`EIMP_OFF_MISC_STAT, 32'h0);
		acc(1'b1, `EIMP_OFF_MISC_EN, 32'hFFFF_FFFF);
		rchk(`EIMP_OFF_MISC_EN, 32'hF);
		acc(1'b1, `EIMP_OFF_RX_LIMIT, 32'hFFFF_FFFF);
		rchk(`EIMP_OFF_RX_LIMIT, 32'h3F);
		acc(1'b1, 8'h40, 32'hFFFF_FFFF);
		rchk(8'h40, 32'h0);
		acc(1'b1, `EIMP_OFF_MISC_EN, 32'h0);
		$display("register test done");
	endtask
	task t_misc;
		want <= 28'h000000F;
		for (int i = 0; i < 4; i++) begin
			acc(1'b1, `EIMP_OFF_MISC_EN, 32'h1 << i);
			rchk(`EIMP_OFF_MISC_STAT, 32'h1 << i);
			check(32'(misc_pulse_q), 32'h1);
		end
		acc(1'b1, `EIMP_OFF_MISC_EN, 32'h0);
		repeat (2) @(posedge mclk);
		check(32'(misc_pulse_q), 32'h0);
		want <= 28'h0;
		$display("misc test done");
	endtask
	task t_masks;
		want <= {8'hA5, 8'h5A, 8'hC3, 4'h0};
		acc(1'b1, `EIMP_OFF_RX_THR_EN, 32'h0F);
		acc(1'b1, `EIMP_OFF_RX_EN, 32'hF0);
		acc(1'b1, `EIMP_OFF_TX_EN, 32'h0F);
		rchk(`EIMP_OFF_RX_THR_STAT, 32'h05);
		rchk(`EIMP_OFF_RX_STAT, 32'h50);
		rchk(`EIMP_OFF_TX_STAT, 32'h03);
		check(32'({receive_threshold_interrupt_pulse, rx_pulse, tx_pulse}),
			32'h7);
		want <= 28'h0;
		repeat (4) @(posedge mclk);
		check(32'({receive_threshold_interrupt_pulse, rx_pulse, tx_pulse}),
			32'h0);
		$display("mask test done");
	endtask
	task t_irq;
		rchk(`EIMP_OFF_EVT_STAT, 32'hF);
		check(32'(irq_q), 32'h0);
		acc(1'b1, `EIMP_OFF_EVT_EN, 32'h4);
		repeat (2) @(posedge mclk);
		check(32'(irq_q), 32'h1);
		acc(1'b1, `EIMP_OFF_EVT_CLR, 32'h4);
		rchk(`EIMP_OFF_EVT_STAT, 32'hB);
		check(32'(irq_q), 32'h0);
		acc(1'b1, `EIMP_OFF_EVT_CLR, 32'hF);
		rchk(`EIMP_OFF_EVT_STAT, 32'h0);
		$display("event test done");
	endtask
	// Pulses rx and tx source bit 0 n times, then checks the rise counts
	task burst(input int n, input int erx, input int etx);
		b_rx = rx_rises;
		b_tx = tx_rises;
		repeat (n) begin
			want <= 28'h0001010;
			repeat (4) @(posedge mclk);
			want <= 28'h0;
			repeat (4) @(posedge mclk);
		end
		check(rx_rises - b_rx, erx);
		check(tx_rises - b_tx, etx);
	endtask
	task t_pace;
		acc(1'b1, `EIMP_OFF_RX_EN, 32'h01);
		acc(1'b1, `EIMP_OFF_TX_EN, 32'h01);
		acc(1'b1, `EIMP_OFF_RX_LIMIT, 32'h02);
		acc(1'b1, `EIMP_OFF_TX_LIMIT, 32'h01);
		// Prescaler zero freezes the window, so the budget is exact
		acc(1'b1, `EIMP_OFF_INT_CONTROL, 32'h0003_0000);
		burst(5, 2, 1);
		acc(1'b1, `EIMP_OFF_INT_CONTROL, 32'hFFFF_F001);
		rchk(`EIMP_OFF_INT_CONTROL, 32'h0003_0001);
		repeat (3100) @(posedge mclk);
		burst(1, 1, 1);
		acc(1'b1, `EIMP_OFF_INT_CONTROL, 32'h0);
		burst(3, 3, 3);
		$display("pacing test done");
	endtask
	task conclude;
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge mclk);
		arst_n <= 1'b1;
		t_regs;
		t_misc;
		t_masks;
		t_irq;
		t_pace;
		conclude;
	end
	// Tests take about 3300 cycles; a hang is cut well beyond that
	initial begin
		repeat (20000) @(posedge mclk);
		err_count++;
		$display("MISMATCH t=%0t watchdog expired", $time);
		conclude;
	end
endmodule
